// >>> src/five_band_parametric_eq.sv
// Five-band parametric equaliser in the playback path ahead of the DAC.
// Assumes a synchronous sample stream and a simple register write/read port.
//
// Functional notes
// - Filtering sits in the playback path only while the equaliser is enabled.
// - Enable is bit 0 of the first control register at index 2Ah.
// - Two modes exist: fixed five-band and custom coefficient mode.
// - Fixed mode tunes bands to 100, 300, 875, 2400, 6900 Hz at 48 kHz.
// - Fixed mode bandwidths are preset and cannot be changed by software.
// - Band frequencies scale in proportion with the selected sample rate.
// - Gain codes span -12 dB to +12 dB in 1 dB steps; 25..31 reserved.
// - Band gains sit at 15:11, 10:6, 5:1 and 15:11, 10:6 of two registers.
// - Custom mode lets software set each band's frequency and bandwidth.
// - Custom mode reuses the same enable bit and gain fields.
// - Custom coefficients live in registers 44 to 61.
// - Band one is a low shelf, two to four peak, five a high shelf.
`timescale 1ns/10ps
module five_band_parametric_eq #(
    parameter int SAMPLE_W   = 24,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire eq_pkg::reg_req_t    reg_req,
    output logic              [15:0] reg_rdata,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic [SAMPLE_W-1:0] in_data,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic      [SAMPLE_W-1:0] out_data
);
    import eq_pkg::*;

    typedef struct packed {
        eq_phase_t                           phase;
        logic [2:0]                          band;
        logic signed [ACC_W-1:0]             acc;
        logic [1:0][15:0]                    ctl;
        logic [COEF_REGS-1:0][15:0]          coef;
        logic [BAND_COUNT-1:0][ACC_W-1:0]    lp;
        logic [BAND_COUNT-1:0][ACC_W-1:0]    bp;
        band_cfg_t [BAND_COUNT-1:0]          cfg;
        logic [SAMPLE_W-1:0]                 out;
        logic                                out_valid;
        logic [15:0]                         rdata;
    } eq_state_t;

    eq_state_t                        s;
    eq_state_t                        next_s;
    logic                             f_valid;
    logic                             take;
    logic [SAMPLE_W-1:0]              f_data;
    logic                             on_now;
    logic                             custom_now;
    logic [BAND_COUNT-1:0][GAIN_W-1:0] gain_codes;
    logic [7:0]                       wr_idx;
    logic signed [ACC_W-1:0]          band_y;
    logic signed [ACC_W-1:0]          band_lp;
    logic signed [ACC_W-1:0]          band_bp;

    // =========================================================
    // Helpers

    // Register read mux; unmapped indices read as zero
    function automatic logic [15:0] read_reg(
        input logic [7:0] a,
        input eq_state_t  st
    );
        logic [7:0] i;
        i = a - ADDR_COEF_FIRST;
        if (a == ADDR_CTL_ONE) begin
            return st.ctl[0];
        end else if (a == ADDR_CTL_TWO) begin
            return st.ctl[1];
        end else if (a >= ADDR_COEF_FIRST && a <= ADDR_COEF_LAST) begin
            return st.coef[i[4:0]];
        end
        return 16'h0000;
    endfunction

    // Saturate the wide accumulator to the sample width
    function automatic logic [SAMPLE_W-1:0] clip(
        input logic signed [ACC_W-1:0] v
    );
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        hi = $signed({{(ACC_W-SAMPLE_W+1){1'b0}}, {(SAMPLE_W-1){1'b1}}});
        lo = $signed({{(ACC_W-SAMPLE_W+1){1'b1}}, {(SAMPLE_W-1){1'b0}}});
        if (v > hi) begin
            return hi[SAMPLE_W-1:0];
        end else if (v < lo) begin
            return lo[SAMPLE_W-1:0];
        end
        return v[SAMPLE_W-1:0];
    endfunction

    // =========================================================
    // Input buffer; its ready is the block's in_ready
    eq_sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (f_valid),
        .out_ready (take),
        .out_data  (f_data)
    );

    // =========================================================
    // One shared band section, stepped through the five bands
    eq_band_step #(
        .W (ACC_W)
    ) u_band (
        .x       (s.acc),
        .lp      (s.lp[s.band]),
        .bp      (s.bp[s.band]),
        .cfg     (s.cfg[s.band]),
        .y       (band_y),
        .lp_next (band_lp),
        .bp_next (band_bp)
    );

    // =========================================================
    // Control field decode
    assign on_now        = s.ctl[0][ON_BIT];
    assign custom_now    = s.ctl[1][MODE_BIT];
    assign gain_codes[0] = s.ctl[0][B1_LSB +: GAIN_W];
    assign gain_codes[1] = s.ctl[0][B2_LSB +: GAIN_W];
    assign gain_codes[2] = s.ctl[0][B3_LSB +: GAIN_W];
    assign gain_codes[3] = s.ctl[1][B4_LSB +: GAIN_W];
    assign gain_codes[4] = s.ctl[1][B5_LSB +: GAIN_W];
    assign wr_idx        = reg_req.addr - ADDR_COEF_FIRST;

    // Samples are taken only when idle and the output slot is free
    assign take      = (s.phase == ST_IDLE) && f_valid && !s.out_valid;
    assign out_valid = s.out_valid;
    assign out_data  = s.out;
    assign reg_rdata = s.rdata;

    // =========================================================
    // Register access, sample capture and band sequencing
    always_comb begin
        next_s = s;
        if (reg_req.read) begin
            next_s.rdata = read_reg(reg_req.addr, s);
        end
        if (reg_req.write) begin
            if (reg_req.addr == ADDR_CTL_ONE) begin
                next_s.ctl[0] = reg_req.wdata;
            end else if (reg_req.addr == ADDR_CTL_TWO) begin
                next_s.ctl[1] = reg_req.wdata;
            end else if (reg_req.addr >= ADDR_COEF_FIRST
                         && reg_req.addr <= ADDR_COEF_LAST) begin
                next_s.coef[wr_idx[4:0]] = reg_req.wdata;
            end
        end
        if (s.out_valid && out_ready) begin
            next_s.out_valid = 1'b0;
        end
        unique case (s.phase)
            ST_IDLE: begin
                if (take) begin
                    // Settings frozen here for the whole sample
                    for (int i = 0; i < BAND_COUNT; i++) begin
                        next_s.cfg[i].k = gain_k(gain_codes[i]);
                        if (i == 0) begin
                            next_s.cfg[i].shape = SHAPE_LOW;
                        end else if (i == BAND_COUNT - 1) begin
                            next_s.cfg[i].shape = SHAPE_HIGH;
                        end else begin
                            next_s.cfg[i].shape = SHAPE_PEAK;
                        end
                        if (custom_now) begin
                            next_s.cfg[i].f = s.coef[2 * i];
                            next_s.cfg[i].q = s.coef[2 * i + 1];
                        end else begin
                            // Normalised tuning tracks the sample rate
                            next_s.cfg[i].f = FIX_F[i];
                            next_s.cfg[i].q = FIX_Q;
                        end
                    end
                    next_s.acc = {{(ACC_W-SAMPLE_W){f_data[SAMPLE_W-1]}}, f_data};
                    next_s.band = 3'd0;
                    if (on_now) begin
                        next_s.phase = ST_RUN;
                    end else begin
                        // Bypass copies the sample and flushes history
                        next_s.out       = f_data;
                        next_s.out_valid = 1'b1;
                        next_s.lp        = '0;
                        next_s.bp        = '0;
                    end
                end
            end
            ST_RUN: begin
                // Bands run in series, one per cycle
                next_s.acc          = band_y;
                next_s.lp[s.band]   = band_lp;
                next_s.bp[s.band]   = band_bp;
                if (s.band == 3'(BAND_COUNT - 1)) begin
                    next_s.out       = clip(band_y);
                    next_s.out_valid = 1'b1;
                    next_s.phase     = ST_IDLE;
                end else begin
                    next_s.band = s.band + 3'd1;
                end
            end
        endcase
    end

    // State register; control registers come up with the equaliser off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s        <= '0;
            s.ctl[0] <= CTL_ONE_RESET;
            s.ctl[1] <= CTL_TWO_RESET;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_bypass_exact: assert property (
        take && !on_now |=> out_valid && out_data == $past(f_data)
    ) else $error("bypassed sample was altered");

    a_filter_latency: assert property (
        take && on_now |=> (!out_valid)[*5] ##1 out_valid
    ) else $error("filtered sample not ready after five bands");

    a_cfg_frozen: assert property (
        (s.phase == ST_RUN) ##1 (s.phase == ST_RUN) |-> $stable(s.cfg)
    ) else $error("band settings changed inside a sample");

    a_enable_write: assert property (
        reg_req.write && reg_req.addr == ADDR_CTL_ONE
        |=> s.ctl[0] == $past(reg_req.wdata)
    ) else $error("first control register not written");

    a_coef_write: assert property (
        reg_req.write && reg_req.addr == ADDR_COEF_LAST
        |=> s.coef[COEF_REGS-1] == $past(reg_req.wdata)
    ) else $error("last coefficient register not written");

    a_fixed_freq: assert property (
        take && !custom_now |=> s.cfg[0].f == FIX_F[0]
            && s.cfg[4].f == FIX_F[4] && s.cfg[2].q == FIX_Q
    ) else $error("fixed tuning not applied");

    a_custom_freq: assert property (
        take && custom_now && !reg_req.write
        |=> s.cfg[1].f == s.coef[2] && s.cfg[4].q == s.coef[9]
    ) else $error("custom coefficients not applied");

    a_zero_gain: assert property (
        take && (gain_codes[0] == GAIN_ZERO_DB || gain_codes[0] > GAIN_MAX)
        |=> s.cfg[0].k == 16'h0000
    ) else $error("0 dB or reserved code gave nonzero gain");

    a_band_shapes: assert property (
        s.phase == ST_RUN |-> s.cfg[0].shape == SHAPE_LOW
            && s.cfg[2].shape == SHAPE_PEAK && s.cfg[4].shape == SHAPE_HIGH
    ) else $error("band shape wrong");

    // Register port, gain code ends and output slot
    a_ctl_two_write: assert property (
        reg_req.write && reg_req.addr == ADDR_CTL_TWO
        |=> s.ctl[1] == $past(reg_req.wdata)
    ) else $error("second control register not written");

    a_read_ctl_two: assert property (
        reg_req.read && reg_req.addr == ADDR_CTL_TWO
        |=> reg_rdata == $past(s.ctl[1])
    ) else $error("second control register read back wrong");

    a_unmapped_zero: assert property (
        reg_req.read && (reg_req.addr < ADDR_CTL_ONE || reg_req.addr > ADDR_COEF_LAST)
        |=> reg_rdata == 16'h0000
    ) else $error("unmapped register read nonzero");

    a_gain_top: assert property (
        take && gain_codes[4] == GAIN_MAX
        |=> s.cfg[4].k == 16'h2FB2
    ) else $error("plus twelve code gave wrong gain");

    a_gain_floor: assert property (
        take && gain_codes[0] == 5'h00
        |=> s.cfg[0].k == 16'hF405
    ) else $error("minus twelve code gave wrong gain");

    a_output_held: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)
    ) else $error("output sample dropped before it was taken");
endmodule

// >>> shared/eq_pkg.sv
// Constants, types and helpers shared by the five-band equaliser files.
// Assumes one 10 MHz system clock and audio samples arriving as a stream.
package eq_pkg;

    // =========================================================
    // Widths and counts
    localparam int SAMPLE_W   = 24;
    localparam int ACC_W      = 32;
    localparam int BAND_COUNT = 5;
    localparam int COEF_REGS  = 18;
    localparam int FIFO_DEPTH = 16;
    localparam int GAIN_W     = 5;

    // =========================================================
    // Register indices and field positions
    localparam logic [7:0] ADDR_CTL_ONE    = 8'h2A;
    localparam logic [7:0] ADDR_CTL_TWO    = 8'h2B;
    localparam logic [7:0] ADDR_COEF_FIRST = 8'h2C;
    localparam logic [7:0] ADDR_COEF_LAST  = 8'h3D;
    localparam int ON_BIT   = 0;
    localparam int MODE_BIT = 0;
    localparam int B1_LSB   = 11;
    localparam int B2_LSB   = 6;
    localparam int B3_LSB   = 1;
    localparam int B4_LSB   = 11;
    localparam int B5_LSB   = 6;

    // =========================================================
    // Values after reset: equaliser off, every band at 0 dB
    localparam logic [15:0] CTL_ONE_RESET = 16'h6318;
    localparam logic [15:0] CTL_TWO_RESET = 16'h6300;

    // =========================================================
    // Gain codes and fixed-point scaling
    localparam logic [4:0] GAIN_ZERO_DB = 5'h0C;
    localparam logic [4:0] GAIN_MAX     = 5'h18;
    localparam int SHIFT_FQ = 14;
    localparam int SHIFT_K  = 12;

    // Tuning 2*sin(pi*fc/fs) in Q2.14 for 100/300/875/2400/6900 Hz at 48 kHz
    localparam logic [BAND_COUNT-1:0][15:0] FIX_F =
        {16'h37DB, 16'h1406, 16'h0754, 16'h0283, 16'h00D6};
    // Preset damping of every band, Q2.14 (unity)
    localparam logic [15:0] FIX_Q = 16'h4000;

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        SHAPE_LOW  = 2'b00,
        SHAPE_PEAK = 2'b01,
        SHAPE_HIGH = 2'b10
    } band_shape_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } eq_phase_t;

    typedef struct packed {
        logic signed [15:0] f;
        logic signed [15:0] q;
        logic signed [15:0] k;
        band_shape_t        shape;
    } band_cfg_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } reg_req_t;

    // =========================================================
    // Gain code to (linear gain - 1) in Q4.12; reserved codes act as 0 dB
    function automatic logic signed [15:0] gain_k(input logic [4:0] code);
        unique case (code)
            5'h00: return 16'hF405;
            5'h01: return 16'hF482;
            5'h02: return 16'hF50F;
            5'h03: return 16'hF5AD;
            5'h04: return 16'hF65F;
            5'h05: return 16'hF726;
            5'h06: return 16'hF805;
            5'h07: return 16'hF8FF;
            5'h08: return 16'hFA19;
            5'h09: return 16'hFB54;
            5'h0A: return 16'hFCB5;
            5'h0B: return 16'hFE43;
            5'h0D: return 16'h01F4;
            5'h0E: return 16'h0424;
            5'h0F: return 16'h069A;
            5'h10: return 16'h095C;
            5'h11: return 16'h0C74;
            5'h12: return 16'h0FED;
            5'h13: return 16'h13D1;
            5'h14: return 16'h1831;
            5'h15: return 16'h1D18;
            5'h16: return 16'h2299;
            5'h17: return 16'h28C5;
            5'h18: return 16'h2FB2;
            default: return 16'h0000;
        endcase
    endfunction

endpackage

// >>> src/eq_sample_fifo.sv
// Sample FIFO in front of the equaliser datapath.
// Assumes DEPTH is a power of two; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module eq_sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic        full;
    logic        empty;

    // =========================================================
    // Status: extra pointer bit tells full from empty
    assign empty     = (s.wr == s.rd);
    assign full      = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s.mem[s.rd[AW-1:0]];

    // Push and pop may happen in the same cycle
    always_comb begin
        next_s = s;
        if (in_valid && !full) begin
            next_s.mem[s.wr[AW-1:0]] = in_data;
            next_s.wr = s.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_s.rd = s.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// >>> src/eq_band_step.sv
// One equaliser band: state-variable section plus gain blend, combinational.
// Assumes the caller holds the section state and registers the results.
`timescale 1ns/10ps
module eq_band_step #(
    parameter int W = 32
) (
    input  wire logic signed [W-1:0] x,
    input  wire logic signed [W-1:0] lp,
    input  wire logic signed [W-1:0] bp,
    input  wire eq_pkg::band_cfg_t   cfg,
    output logic signed      [W-1:0] y,
    output logic signed      [W-1:0] lp_next,
    output logic signed      [W-1:0] bp_next
);
    import eq_pkg::*;

    logic signed [W-1:0] hp;
    logic signed [W-1:0] pick;

    // Signed multiply by a 16-bit coefficient, scaled back down
    function automatic logic signed [W-1:0] scale(
        input logic signed [W-1:0] a,
        input logic signed [15:0]  c,
        input int                  sh
    );
        logic signed [W+15:0] p;
        p = a * c;
        p = p >>> sh;
        return p[W-1:0];
    endfunction

    // =========================================================
    // Section update; the band adds (gain - 1) times its own response
    always_comb begin
        lp_next = lp + scale(bp, cfg.f, SHIFT_FQ);
        hp      = x - lp_next - scale(bp, cfg.q, SHIFT_FQ);
        bp_next = bp + scale(hp, cfg.f, SHIFT_FQ);
        unique case (cfg.shape)
            SHAPE_LOW:  pick = lp_next; // Low shelf
            SHAPE_PEAK: pick = bp_next; // Peaking
            SHAPE_HIGH: pick = hp;      // High shelf
            default:    pick = '0;
        endcase
        y = x + scale(pick, cfg.k, SHIFT_K);
    end
endmodule

// >>> sim/dac_path_sink.sv
// Behavioural model of the converter side that drains the equaliser output.
// Assumes one clock; mode 0 always ready, 1 ready at random, 2 stalled.
`timescale 1ns/10ps
module dac_path_sink (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    output logic            out_ready
);
    // =========================================
    // Ready pattern
    // Random gaps give the slow case; a stall lets the FIFO fill up
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            case (mode)
                2'd0:    out_ready <= 1'b1;
                2'd1:    out_ready <= 1'($urandom_range(0, 1));
                default: out_ready <= 1'b0;
            endcase
        end
    end
endmodule

// >>> sim/five_band_parametric_eq_test.sv
// Self-checking bench for the five-band equaliser: registers, bypass, gains, FIFO.
// Assumes eq_pkg, the design files and the sink model are compiled first.
`timescale 1ns/10ps
module five_band_parametric_eq_test;
    import eq_pkg::*;
    localparam int W = 24;
    logic         clk_sys;
    logic         rst_n;
    reg_req_t     reg_req;
    logic [15:0]  reg_rdata;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    logic [1:0]   mode;
    logic [W-1:0] got[$];
    int           error_cnt;
    int           checked;

    five_band_parametric_eq #(.SAMPLE_W(W), .FIFO_DEPTH(FIFO_DEPTH)) five_band_parametric_eq_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    dac_path_sink dac_path_sink_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .mode(mode), .out_ready(out_ready));

    // =========================================
    // Clock and output monitor
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Every sample the sink accepts, in arrival order
    always @(posedge clk_sys) begin
        if (rst_n && out_valid && out_ready) begin
            got.push_back(out_data);
        end
    end

    // =========================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Control words packed from their fields, independent of the design's decode
    function automatic logic [15:0] ctl_one_word(input logic [4:0] g1, input logic [4:0] g2,
                                                 input logic [4:0] g3, input logic on);
        return {g1, g2, g3, on};
    endfunction

    function automatic logic [15:0] ctl_two_word(input logic [4:0] g4, input logic [4:0] g5,
                                                 input logic custom);
        return {g4, g5, 5'h00, custom};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clk_sys);
        reg_req.write <= 1'b0;
    endtask

    // Read data lands on the same edge that takes the read pulse
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
        @(posedge clk_sys);
        reg_req.read <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic xfer(input logic [W-1:0] x, output logic [W-1:0] y);
        int n;
        n = got.size();
        @(posedge clk_sys);
        in_valid <= 1'b1;
        in_data  <= x;
        do @(posedge clk_sys); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        repeat (40) if (got.size() == n) @(posedge clk_sys);
        y = (got.size() > n) ? got[n] : 'x;
    endtask

    // Flush history by a pass while off, then settle on a constant input
    task automatic dc_run(input logic [15:0] c1, input logic [15:0] c2,
                          input logic [W-1:0] x, output logic [W-1:0] y);
        wr(ADDR_CTL_ONE, 16'h6318);
        xfer(x, y);
        wr(ADDR_CTL_TWO, c2);
        wr(ADDR_CTL_ONE, c1);
        repeat (600) xfer(x, y);
    endtask

    // =========================================
    // Watchdog: the whole run needs well under 40000 cycles
    initial begin
        repeat (80000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end

    // =========================================
    // Main sequence
    initial begin
        logic [15:0]  d;
        logic [15:0]  v;
        logic [7:0]   a;
        logic [W-1:0] x;
        logic [W-1:0] y;
        logic [W-1:0] sv[24];
        int           i;
        void'($urandom(99));
        rst_n     = 1'b0;
        reg_req   = '0;
        in_valid  = 1'b0;
        in_data   = '0;
        mode      = 2'd0;
        error_cnt = 0;
        checked   = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // Values after reset, including the coefficient bank ends
        rd(ADDR_CTL_ONE, d); chk(d, CTL_ONE_RESET);
        rd(ADDR_CTL_TWO, d); chk(d, CTL_TWO_RESET);
        rd(ADDR_COEF_FIRST, d); chk(d, 16'h0000);
        rd(ADDR_COEF_LAST, d); chk(d, 16'h0000);
        // Random write and read back over the whole mapped range
        for (i = 0; i < 16; i++) begin
            a = 8'h2A + 8'($urandom_range(0, 19));
            v = 16'($urandom);
            wr(a, v);
            rd(a, d); chk(d, v);
        end
        // Just outside the bank is not storage
        wr(8'h3E, 16'hFFFF); rd(8'h3E, d); chk(d, 16'h0000);
        wr(8'h29, 16'hFFFF); rd(8'h29, d); chk(d, 16'h0000);
        for (i = 0; i < 18; i++) wr(ADDR_COEF_FIRST + 8'(i), 16'h0000);
        wr(ADDR_CTL_TWO, 16'h6300);
        wr(ADDR_CTL_ONE, 16'h6318);
        // Bypass with a slow sink: bit-exact
        mode <= 2'd1;
        for (i = 0; i < 20; i++) begin
            x = W'($urandom);
            xfer(x, y); chk(y, x);
        end
        mode <= 2'd0;
        // Enabled at 0 dB, then reserved codes, both leave samples intact
        wr(ADDR_CTL_ONE, 16'h6319);
        for (i = 0; i < 8; i++) begin x = W'($urandom); xfer(x, y); chk(y, x); end
        wr(ADDR_CTL_TWO, 16'hFFC0);
        wr(ADDR_CTL_ONE, 16'hFFFF);
        for (i = 0; i < 8; i++) begin x = W'($urandom); xfer(x, y); chk(y, x); end
        // Custom mode with zero tuning after a flush: the low shelf and the peaks have nothing to
        // act on; band five stays at 0 dB since a high-pass with zero tuning passes all
        wr(ADDR_CTL_ONE, 16'h6318);
        x = W'($urandom);
        xfer(x, y);
        chk(y, x);
        wr(ADDR_CTL_TWO, ctl_two_word(5'h18, 5'h0C, 1'b1));
        wr(ADDR_CTL_ONE, ctl_one_word(5'h18, 5'h18, 5'h18, 1'b1));
        for (i = 0; i < 8; i++) begin
            x = W'($urandom);
            xfer(x, y);
            chk(y, x);
        end
        // Constant input: the low shelf moves it, the high shelf leaves it
        x = 24'd100000;
        dc_run(16'hC319, 16'h6300, x, y); chk(32'($signed(y) > 300000), 32'd1);
        dc_run(16'h0319, 16'h6300, x, y); chk(32'($signed(y) < 50000), 32'd1);
        dc_run(16'h6319, 16'h6600, x, y); // Band five at +12 dB
        chk(32'($signed(y) > 87500 && $signed(y) < 112500), 32'd1);
        // Stalled sink: one sample in the output slot plus a full FIFO
        wr(ADDR_CTL_ONE, 16'h6318);
        mode <= 2'd2;
        repeat (4) @(posedge clk_sys);
        got.delete();
        for (i = 0; i < 24; i++) sv[i] = W'($urandom);
        i = 0;
        in_valid <= 1'b1;
        in_data  <= sv[0];
        repeat (30) begin
            @(posedge clk_sys);
            if (in_ready && i < 23) begin
                i++;
                in_data <= sv[i];
            end
        end
        in_valid <= 1'b0;
        chk(i, FIFO_DEPTH + 1);
        chk(in_ready, 1'b0);
        mode <= 2'd0;
        repeat (200) if (got.size() < i) @(posedge clk_sys);
        chk(got.size(), i);
        for (int k = 0; k < i && k < got.size(); k++) chk(got[k], sv[k]);
        end_of_test();
    end
endmodule
